/* design/efdw_decode.sv */
// Configuration flag decoder with suspend indicator and wake output pin
// Function
// - Flags0 bit1 reports remote wakeup support
// - Flags0 bit0 reports self or bus powered
// - Flags1 bit7 picks LED2 activity-only mode
// - LED2 mode ignored unless pin2 is LED
// - Flags1 bits6:2 make pins 4..0 LEDs
// - Scope bit: deep suspend only, or all three
// - Flags1 bit0 sets suspend indicator polarity
// - Wake bit7 enables wake indication on pin
// - Wake enable clear ignores other wake bits
// - Wake bit6 picks level or single pulse
// - Wake bit5 picks 1.5 ms or 150 ms
// - Wake bit4 sets active sense of wake
// - Wake bit3 picks push-pull or single-sided drive
// - Wake bit2 picks network events or link-up
// - Only enabled gpio pins cause wake
// - Pattern and address enables under network wake
// - Loaded bytes used only with A5 signature
`default_nettype none
module efdw_decode #(
  parameter int unsigned PULSE_SHORT_CYC = efdw_pkg::PULSE_SHORT_CYC,
  parameter int unsigned PULSE_LONG_CYC  = efdw_pkg::PULSE_LONG_CYC,
  parameter int unsigned NUM_GPIO        = efdw_pkg::NUM_WAKE_GPIO
) (
  input  wire logic                clk_sys_in,
  input  wire logic                sys_rst_in,
  input  wire logic                load_byte_valid_in,
  input  wire logic [7:0]          load_addr_in,
  input  wire logic [7:0]          load_data_in,
  input  wire logic                load_done_in,
  input  wire logic                deep_suspend_state_in,
  input  wire logic                light_suspend_state_in,
  input  wire logic                cable_detach_in,
  input  wire logic [NUM_GPIO-1:0] wake_gpio_in,
  input  wire logic                pattern_packet_in,
  input  wire logic                addr_match_in,
  input  wire logic                link_up_in,
  input  wire logic                wake_ack_in,
  output var efdw_pkg::efdw_cfg_t  cfg_out,
  output logic                     eeprom_used_out,
  output logic                     load_busy_out,
  output logic                     suspend_indicator_pin_out,
  output logic                     wake_output_pin_out,
  output logic                     wake_output_pin_oe_n_out
);

  efdw_pkg::efdw_ld_state_t ld_state_ff;
  efdw_pkg::efdw_cfg_t      cfg_ff;
  logic [7:0]               sig_sh_ff;
  logic [7:0]               f0_sh_ff;
  logic [7:0]               f1_sh_ff;
  logic [7:0]               wk_sh_ff;
  logic [11:0]              en_sh_ff;
  logic                     sig_ok;
  logic                     eeprom_used_ff;
  logic [NUM_GPIO-1:0]      gpio_meta_ff;
  logic [NUM_GPIO-1:0]      gpio_sync_ff;
  logic [NUM_GPIO-1:0]      gpio_prev_ff;
  logic [NUM_GPIO-1:0]      gpio_edge;
  logic                     net_evt;
  logic                     src_evt;
  logic                     wake_trig;
  logic                     wake_level_ff;
  logic                     pulse_busy;
  logic                     wake_active;
  logic                     susp_assert;
  logic                     susp_pin_ff;
  logic                     nxt_wake_pin;
  logic                     nxt_wake_oe_n;
  logic                     wake_pin_ff;
  logic                     wake_oe_n_ff;

  // Loader state: busy from first byte to done
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ld_state_ff <= efdw_pkg::LD_IDLE;
    end else begin
      case (ld_state_ff)
        efdw_pkg::LD_IDLE: begin
          if (load_byte_valid_in && !load_done_in) begin
            ld_state_ff <= efdw_pkg::LD_BUSY;
          end
        end
        efdw_pkg::LD_BUSY: begin
          if (load_done_in) begin
            ld_state_ff <= efdw_pkg::LD_IDLE;
          end
        end
        default: begin
          ld_state_ff <= efdw_pkg::LD_IDLE;
        end
      endcase
    end
  end

  // Shadow copies of the bytes of interest
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sig_sh_ff <= 8'h00;
      f0_sh_ff  <= efdw_pkg::DEF_FLAGS0;
      f1_sh_ff  <= efdw_pkg::DEF_FLAGS1;
      wk_sh_ff  <= efdw_pkg::DEF_WAKE_FLAGS;
      en_sh_ff  <= efdw_pkg::DEF_WAKE_EN;
    end else if (load_byte_valid_in) begin
      if (load_addr_in == efdw_pkg::OFS_SIGNATURE) begin
        sig_sh_ff <= load_data_in;
      end else if (load_addr_in == efdw_pkg::OFS_FLAGS0) begin
        f0_sh_ff <= load_data_in;
      end else if (load_addr_in == efdw_pkg::OFS_WAKE_EN_LO) begin
        en_sh_ff[7:0] <= load_data_in;
      end else if (load_addr_in == efdw_pkg::OFS_WAKE_EN_HI) begin
        en_sh_ff[11:8] <= load_data_in[3:0];
      end else if (load_addr_in == efdw_pkg::OFS_WAKE_FLAGS) begin
        wk_sh_ff <= load_data_in;
      end else if (load_addr_in == efdw_pkg::OFS_FLAGS1) begin
        f1_sh_ff <= load_data_in;
      end
    end
  end

  assign sig_ok = (sig_sh_ff == efdw_pkg::SIGNATURE_OK);

  // Decoded settings, changed only by reset or load completion
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cfg_ff         <= efdw_pkg::DEF_CFG;
      eeprom_used_ff <= 1'b0;
    end else if (load_done_in) begin
      eeprom_used_ff <= sig_ok;
      if (sig_ok) begin
        cfg_ff <= efdw_pkg::decode_cfg(f0_sh_ff, f1_sh_ff,
                                       wk_sh_ff, en_sh_ff);
      end else begin
        cfg_ff <= efdw_pkg::DEF_CFG;
      end
    end
  end

  // Suspend indicator select and polarity
  always_comb begin
    if (cfg_ff.suspend_indicator_scope) begin
      susp_assert = deep_suspend_state_in | light_suspend_state_in |
                    cable_detach_in;
    end else begin
      susp_assert = deep_suspend_state_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      susp_pin_ff <= 1'b1;
    end else begin
      susp_pin_ff <= cfg_ff.suspend_indicator_polarity ?
                     susp_assert : ~susp_assert;
    end
  end

  // Gpio wake pins: two-stage synchroniser then edge detect
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      gpio_meta_ff <= '0;
      gpio_sync_ff <= '0;
      gpio_prev_ff <= '0;
    end else begin
      gpio_meta_ff <= wake_gpio_in;
      gpio_sync_ff <= gpio_meta_ff;
      gpio_prev_ff <= gpio_sync_ff;
    end
  end

  assign gpio_edge = gpio_sync_ff & ~gpio_prev_ff &
                     cfg_ff.gpio_wake_en[NUM_GPIO-1:0];

  // Wake source selection
  assign net_evt = (pattern_packet_in & cfg_ff.wake_pattern_en) |
                   (addr_match_in & cfg_ff.wake_addr_en);
  assign src_evt = cfg_ff.wake_link_src ? link_up_in : net_evt;
  assign wake_trig = cfg_ff.wake_en & (src_evt | (|gpio_edge));

  // Level mode: held until acknowledged; a new event wins over the ack
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wake_level_ff <= 1'b0;
    end else if (wake_trig && !cfg_ff.wake_pulse) begin
      wake_level_ff <= 1'b1;
    end else if (wake_ack_in || !cfg_ff.wake_en) begin
      wake_level_ff <= 1'b0;
    end
  end

  efdw_pulse_timer #(
    .SHORT_CYC (PULSE_SHORT_CYC),
    .LONG_CYC  (PULSE_LONG_CYC),
    .W         (efdw_pkg::TMR_W)
  ) u_pulse (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (wake_trig & cfg_ff.wake_pulse),
    .long_in    (cfg_ff.wake_long),
    .busy_out   (pulse_busy)
  );

  assign wake_active = cfg_ff.wake_pulse ? pulse_busy : wake_level_ff;

  // Wake pin driver: value and enable (enable low while driving)
  always_comb begin
    if (!cfg_ff.wake_en) begin
      nxt_wake_pin  = 1'b0;
      nxt_wake_oe_n = 1'b1;
    end else if (cfg_ff.wake_push_pull) begin
      nxt_wake_oe_n = 1'b0;
      nxt_wake_pin  = wake_active ? cfg_ff.wake_pol : ~cfg_ff.wake_pol;
    end else begin
      nxt_wake_oe_n = ~wake_active;
      nxt_wake_pin  = cfg_ff.wake_pol;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wake_pin_ff  <= 1'b0;
      wake_oe_n_ff <= 1'b1;
    end else begin
      wake_pin_ff  <= nxt_wake_pin;
      wake_oe_n_ff <= nxt_wake_oe_n;
    end
  end

  assign cfg_out                   = cfg_ff;
  assign eeprom_used_out           = eeprom_used_ff;
  assign load_busy_out             = (ld_state_ff == efdw_pkg::LD_BUSY);
  assign suspend_indicator_pin_out = susp_pin_ff;
  assign wake_output_pin_out       = wake_pin_ff;
  assign wake_output_pin_oe_n_out  = wake_oe_n_ff;

  // Checking
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  logic [23:0] a_len_ff;
  logic        a_long_ff;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      a_len_ff  <= 24'h000000;
      a_long_ff <= 1'b0;
    end else if (pulse_busy) begin
      a_len_ff <= a_len_ff + 24'h000001;
    end else begin
      a_len_ff  <= 24'h000000;
      a_long_ff <= cfg_ff.wake_long;
    end
  end

  property p_default_cfg;
    load_done_in && !sig_ok |=> cfg_ff == efdw_pkg::DEF_CFG;
  endproperty
  a_default_cfg: assert property (p_default_cfg)
    else $error("Defaults not applied on bad signature");

  property p_power;
    load_done_in && sig_ok |=>
      cfg_out.self_powered == $past(f0_sh_ff[efdw_pkg::F0_POWER]);
  endproperty
  a_power: assert property (p_power)
    else $error("Power method not taken from flags0");

  property p_rwake;
    load_done_in && sig_ok |=>
      cfg_out.remote_wakeup == $past(f0_sh_ff[efdw_pkg::F0_RWAKE]);
  endproperty
  a_rwake: assert property (p_rwake)
    else $error("Remote wakeup not taken from flags0");

  property p_led;
    load_done_in && sig_ok |=>
      cfg_out.pin_led_select == $past(f1_sh_ff[6:2]);
  endproperty
  a_led: assert property (p_led)
    else $error("Pin LED selects wrong");

  property p_led2;
    !cfg_out.pin_led_select[2] |-> !cfg_out.led2_mode_select;
  endproperty
  a_led2: assert property (p_led2)
    else $error("LED2 mode active without pin2 LED");

  property p_susp_deep;
    deep_suspend_state_in && !load_done_in |=>
      suspend_indicator_pin_out == cfg_ff.suspend_indicator_polarity;
  endproperty
  a_susp_deep: assert property (p_susp_deep)
    else $error("Suspend indicator not asserted in deep suspend");

  property p_susp_idle;
    !deep_suspend_state_in && !light_suspend_state_in &&
      !cable_detach_in && !load_done_in |=>
      suspend_indicator_pin_out != cfg_ff.suspend_indicator_polarity;
  endproperty
  a_susp_idle: assert property (p_susp_idle)
    else $error("Suspend indicator asserted while awake");

  property p_wake_off;
    !cfg_ff.wake_en && !load_done_in |=> wake_output_pin_oe_n_out;
  endproperty
  a_wake_off: assert property (p_wake_off)
    else $error("Wake pin driven while disabled");

  property p_level;
    wake_trig && !cfg_ff.wake_pulse && !load_done_in |=>
      wake_level_ff ##1 wake_output_pin_out == cfg_ff.wake_pol;
  endproperty
  a_level: assert property (p_level)
    else $error("Wake level not raised on event");

  property p_pulse_len;
    $fell(pulse_busy) |->
      a_len_ff == (a_long_ff ? 24'(PULSE_LONG_CYC)
                             : 24'(PULSE_SHORT_CYC));
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("Wake pulse length wrong");

  property p_oe;
    cfg_ff.wake_en && !cfg_ff.wake_push_pull && !wake_active &&
      !load_done_in |=> wake_output_pin_oe_n_out;
  endproperty
  a_oe: assert property (p_oe)
    else $error("Single-sided driver drives while idle");

  property p_link_src;
    cfg_ff.wake_en && cfg_ff.wake_link_src && !cfg_ff.wake_pulse &&
      !wake_level_ff && !link_up_in && gpio_edge == '0 &&
      !load_done_in |=> !wake_level_ff;
  endproperty
  a_link_src: assert property (p_link_src)
    else $error("Wake raised without link-up");

  c_pulse_short: cover property ($fell(pulse_busy) && !a_long_ff);
  c_level_ack: cover property (wake_level_ff ##1 !wake_level_ff);
  c_eeprom_load: cover property (load_done_in && sig_ok);
  c_gpio_wake: cover property (|gpio_edge && cfg_ff.wake_en);

endmodule
`default_nettype wire

/* design/efdw_pkg.sv */
// Package of constants, types and decoding for the flag decoder
`default_nettype none
package efdw_pkg;

  // Byte offsets in the configuration image
  localparam logic [7:0] OFS_SIGNATURE  = 8'h00;
  localparam logic [7:0] OFS_FLAGS0     = 8'h09;
  localparam logic [7:0] OFS_WAKE_EN_LO = 8'h1e;
  localparam logic [7:0] OFS_WAKE_EN_HI = 8'h1f;
  localparam logic [7:0] OFS_WAKE_FLAGS = 8'h20;
  localparam logic [7:0] OFS_FLAGS1     = 8'h21;

  // Signature and hardware defaults
  localparam logic [7:0]  SIGNATURE_OK   = 8'ha5;
  localparam logic [7:0]  DEF_FLAGS0     = 8'h1b;
  localparam logic [7:0]  DEF_FLAGS1     = 8'h00;
  localparam logic [7:0]  DEF_WAKE_FLAGS = 8'h00;
  localparam logic [11:0] DEF_WAKE_EN    = 12'h000;

  // Field positions, flags byte 0
  localparam int unsigned F0_POWER = 0;
  localparam int unsigned F0_RWAKE = 1;
  // Field positions, flags byte 1
  localparam int unsigned F1_POL    = 0;
  localparam int unsigned F1_SCOPE  = 1;
  localparam int unsigned F1_LED_LO = 2;
  localparam int unsigned F1_LED_HI = 6;
  localparam int unsigned F1_LED2   = 7;
  localparam int unsigned F1_PIN2   = 4;
  // Field positions, wake flags byte
  localparam int unsigned WK_ADDR  = 0;
  localparam int unsigned WK_PAT   = 1;
  localparam int unsigned WK_SRC   = 2;
  localparam int unsigned WK_PP    = 3;
  localparam int unsigned WK_POL   = 4;
  localparam int unsigned WK_LEN   = 5;
  localparam int unsigned WK_PULSE = 6;
  localparam int unsigned WK_EN    = 7;

  // Timing
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned PULSE_SHORT_US = 1500;
  localparam int unsigned PULSE_LONG_US  = 150000;
  localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_US * CLK_MHZ;
  localparam int unsigned PULSE_LONG_CYC  = PULSE_LONG_US * CLK_MHZ;
  localparam int unsigned TMR_W           = 23;

  localparam int unsigned NUM_WAKE_GPIO = 12;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_RUN  = 2'b01
  } efdw_tmr_state_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_BUSY = 2'b01
  } efdw_ld_state_t;

  typedef struct packed {
    logic        remote_wakeup;
    logic        self_powered;
    logic        led2_mode_select;
    logic [4:0]  pin_led_select;
    logic        suspend_indicator_scope;
    logic        suspend_indicator_polarity;
    logic        wake_en;
    logic        wake_pulse;
    logic        wake_long;
    logic        wake_pol;
    logic        wake_push_pull;
    logic        wake_link_src;
    logic        wake_pattern_en;
    logic        wake_addr_en;
    logic [11:0] gpio_wake_en;
  } efdw_cfg_t;

  // Turns raw flag bytes into the decoded setting set
  function automatic efdw_cfg_t decode_cfg(input logic [7:0]  f0,
                                           input logic [7:0]  f1,
                                           input logic [7:0]  wk,
                                           input logic [11:0] en);
    efdw_cfg_t c;
    c = '0;
    c.remote_wakeup  = f0[F0_RWAKE];
    c.self_powered   = f0[F0_POWER];
    c.pin_led_select = f1[F1_LED_HI:F1_LED_LO];
    c.led2_mode_select = f1[F1_LED2] & f1[F1_PIN2];
    c.suspend_indicator_scope    = f1[F1_SCOPE];
    c.suspend_indicator_polarity = f1[F1_POL];
    if (wk[WK_EN]) begin
      c.wake_en         = 1'b1;
      c.wake_pulse      = wk[WK_PULSE];
      c.wake_long       = wk[WK_LEN] & wk[WK_PULSE];
      c.wake_pol        = wk[WK_POL];
      c.wake_push_pull  = wk[WK_PP];
      c.wake_link_src   = wk[WK_SRC];
      c.wake_pattern_en = wk[WK_PAT] & ~wk[WK_SRC];
      c.wake_addr_en    = wk[WK_ADDR] & ~wk[WK_SRC];
      c.gpio_wake_en    = en;
    end
    return c;
  endfunction

  localparam efdw_cfg_t DEF_CFG =
    decode_cfg(DEF_FLAGS0, DEF_FLAGS1, DEF_WAKE_FLAGS, DEF_WAKE_EN);

endpackage
`default_nettype wire

/* design/efdw_pulse_timer.sv */
// Non-retriggerable wake pulse timer
`default_nettype none
module efdw_pulse_timer #(
  parameter int unsigned SHORT_CYC = efdw_pkg::PULSE_SHORT_CYC,
  parameter int unsigned LONG_CYC  = efdw_pkg::PULSE_LONG_CYC,
  parameter int unsigned W         = efdw_pkg::TMR_W
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic start_in,
  input  wire logic long_in,
  output logic      busy_out
);

  efdw_pkg::efdw_tmr_state_t state_ff;
  logic [W-1:0]              cnt_ff;

  localparam logic [W-1:0] SHORT_LOAD = W'(SHORT_CYC - 1);
  localparam logic [W-1:0] LONG_LOAD  = W'(LONG_CYC - 1);

  // Start only from idle, so a pulse in flight is never stretched
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_ff <= efdw_pkg::TMR_IDLE;
      cnt_ff   <= '0;
    end else begin
      case (state_ff)
        efdw_pkg::TMR_IDLE: begin
          if (start_in) begin
            state_ff <= efdw_pkg::TMR_RUN;
            cnt_ff   <= long_in ? LONG_LOAD : SHORT_LOAD;
          end
        end
        efdw_pkg::TMR_RUN: begin
          if (cnt_ff == '0) begin
            state_ff <= efdw_pkg::TMR_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= efdw_pkg::TMR_IDLE;
        end
      endcase
    end
  end

  assign busy_out = (state_ff == efdw_pkg::TMR_RUN);

endmodule
`default_nettype wire

/* verification/efdw_host_model.sv */
// Host wake input with board pull resistor and wake acknowledge
`default_nettype none
module efdw_host_model #(
  parameter int unsigned ACK_DLY = 4
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic wake_pin_in,
  input  wire logic wake_oe_n_in,
  input  wire logic active_high_in,
  input  wire logic ack_en_in,
  output logic      wire_level_out,
  output logic      seen_out,
  output logic      ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned held_ff;
  // Released pin settles to the idle level through the board resistor
  assign wire_level_out = wake_oe_n_in ? ~active_high_in : wake_pin_in;
  assign seen_out = (wire_level_out === active_high_in);
  // Host acknowledges a held wake once, after a fixed delay
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !seen_out) begin
      held_ff <= 0;
      ack_out <= 1'b0;
    end else begin
      held_ff <= held_ff + 1;
      ack_out <= ack_en_in && (held_ff == ACK_DLY);
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Testbench for the flag decoder, suspend indicator and wake pin
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0]  s, f0, f1, wk;
    logic [11:0] en;
    logic        u;
  } efdw_row_t;
  typedef struct {
    logic [7:0]  wk;
    logic [11:0] en;
    logic [3:0]  ev;
    int          n;
  } efdw_wrow_t;
  logic                clk_sys_in = 1'b0;
  logic                sys_rst_in = 1'b1;
  logic                vld = 1'b0;
  logic                done = 1'b0;
  logic [7:0]          addr = 8'h00;
  logic [7:0]          data = 8'h00;
  logic                deep = 1'b0;
  logic                light = 1'b0;
  logic                det = 1'b0;
  logic [11:0]         gpio = 12'h000;
  logic                pat = 1'b0;
  logic                am = 1'b0;
  logic                lnk = 1'b0;
  logic                pol = 1'b0;
  logic                ack_en = 1'b0;
  logic                ack, seen, pin, oe_n, used, busy, susp, lvl;
  efdw_pkg::efdw_cfg_t cfg;
  int                  errors = 0;
  int                  comparisons = 0;
  int                  cyc = 0;
  int                  n;
  efdw_row_t  rows [5] = '{'{8'ha5, 8'h02, 8'h80, 8'h7f, 12'h0ff, 1'b1},
                           '{8'ha5, 8'h01, 8'h90, 8'hff, 12'hfff, 1'b1},
                           '{8'ha5, 8'h03, 8'h7f, 8'hbb, 12'h0a5, 1'b1},
                           '{8'h5a, 8'h00, 8'hff, 8'hff, 12'hfff, 1'b0},
                           '{8'ha5, 8'h00, 8'h03, 8'hd4, 12'h800, 1'b1}};
  efdw_wrow_t wrows [10] = '{'{8'hc2, 12'h000, 4'h1, 10},
                             '{8'he2, 12'h000, 4'h1, 40},
                             '{8'hd2, 12'h000, 4'h1, 10},
                             '{8'h7f, 12'hfff, 4'hf, 0},
                             '{8'hc0, 12'h001, 4'h8, 10},
                             '{8'hc0, 12'h002, 4'h8, 0},
                             '{8'hc9, 12'h000, 4'h2, 10},
                             '{8'hc1, 12'h000, 4'h1, 0},
                             '{8'hc3, 12'h000, 4'h4, 0},
                             '{8'hc7, 12'h000, 4'h3, 0}};

  always #12.5 clk_sys_in = ~clk_sys_in;

  efdw_decode #(
    .PULSE_SHORT_CYC (10),
    .PULSE_LONG_CYC  (40),
    .NUM_GPIO        (12)
  ) DUT (
    .clk_sys_in                (clk_sys_in),
    .sys_rst_in                (sys_rst_in),
    .load_byte_valid_in        (vld),
    .load_addr_in              (addr),
    .load_data_in              (data),
    .load_done_in              (done),
    .deep_suspend_state_in     (deep),
    .light_suspend_state_in    (light),
    .cable_detach_in           (det),
    .wake_gpio_in              (gpio),
    .pattern_packet_in         (pat),
    .addr_match_in             (am),
    .link_up_in                (lnk),
    .wake_ack_in               (ack),
    .cfg_out                   (cfg),
    .eeprom_used_out           (used),
    .load_busy_out             (busy),
    .suspend_indicator_pin_out (susp),
    .wake_output_pin_out       (pin),
    .wake_output_pin_oe_n_out  (oe_n)
  );

  efdw_host_model #(
    .ACK_DLY (4)
  ) host (
    .clk_sys_in     (clk_sys_in),
    .sys_rst_in     (sys_rst_in),
    .wake_pin_in    (pin),
    .wake_oe_n_in   (oe_n),
    .active_high_in (pol),
    .ack_en_in      (ack_en),
    .wire_level_out (lvl),
    .seen_out       (seen),
    .ack_out        (ack)
  );

  function automatic efdw_pkg::efdw_cfg_t want(
      input logic [7:0] s, f0, f1, wk, input logic [11:0] en);
    efdw_pkg::efdw_cfg_t c;
    c = '0;
    if (s !== 8'ha5) begin
      f0 = 8'h1b;
      f1 = 8'h00;
      wk = 8'h00;
      en = 12'h000;
    end
    c.remote_wakeup = f0[1];
    c.self_powered = f0[0];
    c.led2_mode_select = f1[7] & f1[4];
    c.pin_led_select = f1[6:2];
    c.suspend_indicator_scope = f1[1];
    c.suspend_indicator_polarity = f1[0];
    if (wk[7]) begin
      c.wake_en = 1'b1;
      c.wake_pulse = wk[6];
      c.wake_long = wk[6] & wk[5];
      c.wake_pol = wk[4];
      c.wake_push_pull = wk[3];
      c.wake_link_src = wk[2];
      c.wake_pattern_en = wk[1] & ~wk[2];
      c.wake_addr_en = wk[0] & ~wk[2];
      c.gpio_wake_en = en;
    end
    return c;
  endfunction

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  // Loads one image, an unmapped byte included, then applies it
  task automatic load(input logic [7:0] s, f0, f1, wk,
                      input logic [11:0] en);
    logic [7:0] a [7];
    logic [7:0] d [7];
    a = '{8'h00, 8'h09, 8'h22, 8'h21, 8'h20, 8'h1e, 8'h1f};
    d = '{s, f0, 8'hff, f1, wk, en[7:0], {4'hf, en[11:8]}};
    @(posedge clk_sys_in);
    for (int i = 0; i < 7; i++) begin
      addr <= a[i];
      data <= d[i];
      vld <= 1'b1;
      @(posedge clk_sys_in);
      if (i == 3) check(busy === 1'b1, "load busy");
    end
    vld <= 1'b0;
    done <= 1'b1;
    @(posedge clk_sys_in);
    done <= 1'b0;
    pol <= wk[4];
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  // Fires the chosen events twice and counts cycles the host sees wake
  task automatic count_wake(input logic [3:0] ev, output int cnt);
    cnt = 0;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_sys_in);
      pat <= ev[0] && (i == 0 || i == 5);
      am <= ev[1] && (i == 0 || i == 5);
      lnk <= ev[2] && (i == 0 || i == 5);
      gpio <= {11'h000, ev[3] && (i == 0 || i == 5)};
      @(negedge clk_sys_in);
      cnt += int'(seen);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("MISMATCH at %0t: run did not finish", $time);
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_sys_in);
    check(cfg === want(8'h00, 8'h00, 8'h00, 8'h00, 12'h000), "reset cfg");
    check(used === 1'b0 && busy === 1'b0 && susp === 1'b1, "reset pins");
    check(pin === 1'b0 && oe_n === 1'b1, "reset wake pin");
    $display("Test reset done");
    foreach (rows[i]) begin
      load(rows[i].s, rows[i].f0, rows[i].f1, rows[i].wk, rows[i].en);
      check(cfg === want(rows[i].s, rows[i].f0, rows[i].f1, rows[i].wk,
                         rows[i].en), "decoded cfg");
      check(used === rows[i].u && busy === 1'b0, "load status");
      $display("Test cfg row %0d done", i);
    end
    for (int k = 0; k < 4; k++) begin
      load(8'ha5, 8'h00, 8'(k), 8'h00, 12'h000);
      for (int st = 0; st < 8; st++) begin
        @(posedge clk_sys_in);
        {det, light, deep} <= 3'(st);
        repeat (2) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check(susp === ((st[0] | (k[1] & (st[1] | st[2]))) ~^ k[0]),
              "suspend indicator");
      end
      $display("Test suspend %0d done", k);
    end
    foreach (wrows[i]) begin
      load(8'ha5, 8'h00, 8'h00, wrows[i].wk, wrows[i].en);
      count_wake(wrows[i].ev, n);
      check(n == wrows[i].n, "wake pulse length");
      check(oe_n === (!wrows[i].wk[7] || !wrows[i].wk[3]),
            "wake driver type");
      $display("Test wake row %0d done", i);
    end
    load(8'ha5, 8'h00, 8'h00, 8'h9c, 12'h000);
    ack_en <= 1'b1;
    count_wake(4'h1, n);
    check(n == 0 && pin === 1'b0 && oe_n === 1'b0, "level idle");
    @(posedge clk_sys_in);
    lnk <= 1'b1;
    @(posedge clk_sys_in);
    lnk <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check(seen === 1'b1 && pin === 1'b1, "level asserted");
    repeat (10) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check(seen === 1'b0 && oe_n === 1'b0, "level cleared");
    $display("Test level wake done");
    complete_run();
  end
endmodule
`default_nettype wire
